// ==== inc/sgpc_pkg.sv ====
package sgpc_pkg;
  // Clock and output timing
  localparam int CLK_MHZ = 10;
  localparam int OUT_MIN_US = 100;
  localparam int OUT_MAX_US = 2900;
  localparam int OUT_DELAY_CYC = OUT_MIN_US * CLK_MHZ;
  localparam int OUT_MAX_CYC = OUT_MAX_US * CLK_MHZ;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int CTL_REPEAT_MS = 1000;
  localparam int CTL_REPEAT_TICKS = CTL_REPEAT_MS / TICK_MS;

  // Packet shape
  localparam int SER_MAX_DATA = 7;
  localparam int CTL_DATA_LEN = 4;
  localparam logic [1:0] TYPE_MAIN = 2'h0;
  localparam logic [1:0] TYPE_AUX = 2'h1;
  localparam logic [1:0] TYPE_CTL = 2'h2;
  localparam logic [7:0] TRL_SUM_MASK = 8'h38;

  // Receive path sizing
  localparam int Q_DEPTH = 16;
  localparam int Q_STOP = 12;
  localparam int Q_RESUME = 4;
  localparam int HOLD_DEPTH = 3;
  localparam int NUM_TIMERS = 4;

  // Settings and non-volatile store
  localparam int NV_BLK_BYTES = 4;
  localparam logic [15:0] NV_BASE_A = 16'h8000;
  localparam logic [15:0] NV_BASE_B = 16'h8010;
  localparam logic [15:0] NV_LO = 16'h8000;
  localparam logic [15:0] NV_HI = 16'h9FFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CTL_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] service_identity_code;
    logic [7:0] destination_address_code;
  } sgpc_settings_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } sgpc_rx_s;

  typedef enum logic [1:0] {PK_IDLE, PK_SER, PK_CTL, PK_TRL2} sgpc_pkt_e;
  typedef enum logic [1:0] {NV_RESTORE, NV_IDLE, NV_WRITE} sgpc_nv_e;

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  localparam logic [15:0] CRC_DFLT = crc16(16'h0000);
endpackage

// ==== verilog/sgpc_combiner.sv ====
`timescale 1ns/100ps
module sgpc_combiner #(
  parameter int TICK_CYCLES = sgpc_pkg::TICK_CYC,
  parameter int Q_DEPTH = sgpc_pkg::Q_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Coder link
  input wire logic strobe_in,
  output logic [7:0] out_byte_out,
  output logic out_load_out,
  // Transmitter control
  input wire logic [15:0] transmitter_control_word_in,
  // Serial receivers, index 0 main, 1 auxiliary
  input wire sgpc_pkg::sgpc_rx_s [1:0] rx_in,
  output wire logic [1:0] rx_ready_out,
  output wire logic [1:0] q_overflow_out,
  // Soft timers
  input wire logic [sgpc_pkg::NUM_TIMERS-1:0] timer_clear_in,
  input wire logic [1:0] timer_sel_in,
  output logic [15:0] timer_value_out,
  // Settings
  input wire logic program_key_in,
  input wire logic settings_wr_in,
  input wire sgpc_pkg::sgpc_settings_s settings_in,
  output sgpc_pkg::sgpc_settings_s settings_out,
  output logic wdog_reset_out,
  // Non-volatile memory
  output logic [15:0] nv_addr_out,
  output logic [7:0] nv_wdata_out,
  output logic nv_we_out,
  output logic nv_re_out,
  input wire logic [7:0] nv_rdata_in
);
  localparam int QPW = $clog2(Q_DEPTH);
  localparam int QCW = $clog2(Q_DEPTH + 1);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int DLY_W = $clog2(sgpc_pkg::OUT_DELAY_CYC + 1);
  localparam int AST_DLY = sgpc_pkg::OUT_DELAY_CYC + 1;

  // Reset release
  logic [1:0] rst_sync_reg;
  logic rstn;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rstn = rst_sync_reg[1];

  // Tick source
  logic [TW-1:0] tick_cnt_reg;
  logic strobe_pend_reg, tick_pend_reg;
  wire tick_wrap = tick_cnt_reg == TW'(TICK_CYCLES - 1);
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TW'(1);
  end

  // Event arbitration, strictly one grant per cycle
  wire [1:0] hold_rdy;
  wire [1:0] g_rx;
  wire g_strobe = strobe_pend_reg;
  wire g_tick = tick_pend_reg & ~strobe_pend_reg;
  assign g_rx[0] = hold_rdy[0] & ~strobe_pend_reg & ~tick_pend_reg;
  assign g_rx[1] = hold_rdy[1] & ~strobe_pend_reg & ~tick_pend_reg & ~hold_rdy[0];
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      strobe_pend_reg <= 1'b0;
      tick_pend_reg <= 1'b0;
    end else begin
      // New event beats its own service clear
      strobe_pend_reg <= strobe_in | (strobe_pend_reg & ~g_strobe);
      tick_pend_reg <= tick_wrap | (tick_pend_reg & ~g_tick);
    end
  end

  // Receive holding stage and queues
  wire [1:0][QCW-1:0] q_cnt_w;
  wire [1:0][7:0] q_head;
  wire [1:0] q_pop;
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [8:0] hold_mem [sgpc_pkg::HOLD_DEPTH];
    logic [1:0] hold_cnt_reg;
    logic [7:0] q_mem [Q_DEPTH];
    logic [QPW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [QCW-1:0] cnt_reg;
    logic ovf_reg, rdy_reg;
    wire hold_full = hold_cnt_reg == 2'(sgpc_pkg::HOLD_DEPTH);
    wire pop_h = g_rx[ch];
    wire head_err = hold_mem[0][8];
    wire q_full = cnt_reg == QCW'(Q_DEPTH);
    wire q_push = pop_h & ~head_err & ~q_full;
    wire q_ovf = pop_h & ~head_err & q_full;
    wire h_push = rx_in[ch].valid & (~hold_full | pop_h);
    wire h_lost = rx_in[ch].valid & hold_full & ~pop_h;
    wire [1:0] wr_slot = hold_cnt_reg - {1'b0, pop_h};
    always_ff @(posedge clk_sys_in) begin
      for (int i = 0; i < sgpc_pkg::HOLD_DEPTH - 1; i++) begin
        if (pop_h) hold_mem[i] <= hold_mem[i + 1];
      end
      if (h_push) hold_mem[wr_slot] <= {rx_in[ch].err, rx_in[ch].data};
      if (q_push) q_mem[wr_ptr_reg] <= hold_mem[0][7:0];
    end
    always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) begin
        hold_cnt_reg <= 2'h0;
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        cnt_reg <= '0;
        ovf_reg <= 1'b0;
        rdy_reg <= 1'b1;
      end else begin
        hold_cnt_reg <= wr_slot + {1'b0, h_push};
        if (q_push) wr_ptr_reg <= wr_ptr_reg + QPW'(1);
        if (q_pop[ch]) rd_ptr_reg <= rd_ptr_reg + QPW'(1);
        // Push and pop never share a cycle: both are granted events
        if (q_push) cnt_reg <= cnt_reg + QCW'(1);
        else if (q_pop[ch]) cnt_reg <= cnt_reg - QCW'(1);
        ovf_reg <= ovf_reg | q_ovf | h_lost;
        // Hysteresis keeps the handshake from chattering
        if (cnt_reg >= QCW'(sgpc_pkg::Q_STOP)) rdy_reg <= 1'b0;
        else if (cnt_reg <= QCW'(sgpc_pkg::Q_RESUME)) rdy_reg <= 1'b1;
      end
    end
    assign hold_rdy[ch] = hold_cnt_reg != 2'h0;
    assign q_cnt_w[ch] = cnt_reg;
    assign q_head[ch] = q_mem[rd_ptr_reg];
    assign rx_ready_out[ch] = rdy_reg;
    assign q_overflow_out[ch] = ovf_reg;
  end

  // Soft timers
  wire [sgpc_pkg::NUM_TIMERS-1:0][15:0] timer_w;
  wire ctl_start;
  for (genvar t = 0; t < sgpc_pkg::NUM_TIMERS; t++) begin : g_tm
    logic [15:0] cnt_reg;
    wire clr = timer_clear_in[t] | ((t == 0) & ctl_start);
    always_ff @(posedge clk_sys_in or negedge rstn) begin
      if (!rstn) cnt_reg <= 16'h0000;
      else if (clr) cnt_reg <= 16'h0000;
      else if (g_tick) cnt_reg <= cnt_reg + 16'h0001;
    end
    assign timer_w[t] = cnt_reg;
  end
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) timer_value_out <= 16'h0000;
    else timer_value_out <= timer_w[timer_sel_in];
  end

  // Packet scheduling
  sgpc_pkg::sgpc_pkt_e pk_state_reg;
  sgpc_pkg::sgpc_settings_s set_reg;
  logic [1:0] pk_type_reg;
  logic [2:0] pk_len_reg;
  logic [15:0] pk_sum_reg, last_ctl_reg;
  logic pk_src_reg;
  wire st_idle = pk_state_reg == sgpc_pkg::PK_IDLE;
  wire st_ser = pk_state_reg == sgpc_pkg::PK_SER;
  wire st_ctl = pk_state_reg == sgpc_pkg::PK_CTL;
  wire st_trl2 = pk_state_reg == sgpc_pkg::PK_TRL2;
  wire ctl_changed = transmitter_control_word_in != last_ctl_reg;
  wire ctl_timed = timer_w[0] >= 16'(sgpc_pkg::CTL_REPEAT_TICKS);
  wire ctl_due = ctl_changed | ctl_timed;
  wire main_avail = q_cnt_w[0] != '0;
  wire aux_avail = q_cnt_w[1] != '0;
  wire aux_first = (q_cnt_w[1] > QCW'(sgpc_pkg::SER_MAX_DATA)) &
                   (q_cnt_w[0] < QCW'(sgpc_pkg::SER_MAX_DATA));
  wire pick_aux = aux_avail & (aux_first | ~main_avail);
  wire start_ctl = ctl_due | (~main_avail & ~aux_avail);
  wire ser_end = ctl_changed | (q_cnt_w[pk_src_reg] == '0) |
                 (pk_len_reg == 3'(sgpc_pkg::SER_MAX_DATA));
  wire ctl_full = pk_len_reg == 3'(sgpc_pkg::CTL_DATA_LEN);
  wire trl_now = (st_ser & ser_end) | (st_ctl & ctl_full);
  wire [7:0] comp = {pk_type_reg, 3'h0, pk_len_reg};
  wire [15:0] tsum = pk_sum_reg + {8'h00, comp};
  wire [7:0] trl1 = comp | (tsum[15:8] & sgpc_pkg::TRL_SUM_MASK);
  wire [7:0] ctl_byte = (pk_len_reg == 3'h1) ? set_reg.destination_address_code :
                        (pk_len_reg == 3'h2) ? last_ctl_reg[15:8] : last_ctl_reg[7:0];
  wire pop_src = st_idle ? pick_aux : pk_src_reg;
  wire ser_emit = g_strobe & ((st_idle & ~start_ctl) | (st_ser & ~ser_end));
  assign q_pop[0] = ser_emit & ~pop_src;
  assign q_pop[1] = ser_emit & pop_src;
  assign ctl_start = g_strobe & st_idle & start_ctl;
  wire [7:0] next_byte = st_trl2 ? tsum[7:0] :
                         trl_now ? trl1 :
                         (st_idle & start_ctl) ? set_reg.service_identity_code :
                         st_ctl ? ctl_byte : q_head[pop_src];

  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      pk_state_reg <= sgpc_pkg::PK_IDLE;
      pk_type_reg <= sgpc_pkg::TYPE_MAIN;
      pk_len_reg <= 3'h0;
      pk_sum_reg <= 16'h0000;
      pk_src_reg <= 1'b0;
      last_ctl_reg <= sgpc_pkg::CTL_RST;
    end else if (g_strobe) begin
      unique case (pk_state_reg)
        sgpc_pkg::PK_IDLE: begin
          pk_len_reg <= 3'h1;
          pk_sum_reg <= {8'h00, next_byte};
          if (start_ctl) begin
            pk_state_reg <= sgpc_pkg::PK_CTL;
            pk_type_reg <= sgpc_pkg::TYPE_CTL;
            last_ctl_reg <= transmitter_control_word_in;
          end else begin
            pk_state_reg <= sgpc_pkg::PK_SER;
            pk_type_reg <= pick_aux ? sgpc_pkg::TYPE_AUX : sgpc_pkg::TYPE_MAIN;
            pk_src_reg <= pick_aux;
          end
        end
        sgpc_pkg::PK_SER, sgpc_pkg::PK_CTL: begin
          if (trl_now) begin
            pk_state_reg <= sgpc_pkg::PK_TRL2;
          end else begin
            pk_len_reg <= pk_len_reg + 3'h1;
            pk_sum_reg <= pk_sum_reg + {8'h00, next_byte};
          end
        end
        sgpc_pkg::PK_TRL2: pk_state_reg <= sgpc_pkg::PK_IDLE;
      endcase
    end
  end

  // Output byte, held back for the coder's minimum settling time
  logic [DLY_W-1:0] dly_reg;
  logic [7:0] stage_reg, out_byte_reg;
  logic out_load_reg;
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      dly_reg <= '0;
      stage_reg <= 8'h00;
      out_byte_reg <= 8'h00;
      out_load_reg <= 1'b0;
    end else begin
      out_load_reg <= 1'b0;
      if (g_strobe) begin
        stage_reg <= next_byte;
        dly_reg <= DLY_W'(sgpc_pkg::OUT_DELAY_CYC);
      end else if (dly_reg != '0) begin
        dly_reg <= dly_reg - DLY_W'(1);
        if (dly_reg == DLY_W'(1)) begin
          out_byte_reg <= stage_reg;
          out_load_reg <= 1'b1;
        end
      end
    end
  end
  assign out_byte_out = out_byte_reg;
  assign out_load_out = out_load_reg;

  // Settings, CRC and non-volatile copies
  sgpc_pkg::sgpc_nv_e nv_state_reg;
  logic [2:0] nv_idx_reg;
  logic nv_copy_reg, wdog_reg;
  logic [15:0] crc_reg;
  logic [31:0] rd_buf_reg;
  wire [15:0] nv_base = nv_copy_reg ? sgpc_pkg::NV_BASE_B : sgpc_pkg::NV_BASE_A;
  wire [31:0] wr_blk = {set_reg, crc_reg};
  wire rd_ok = sgpc_pkg::crc16(rd_buf_reg[31:16]) == rd_buf_reg[15:0];
  wire crc_bad = sgpc_pkg::crc16(set_reg) != crc_reg;
  wire nv_in_range = (nv_addr_out >= sgpc_pkg::NV_LO) & (nv_addr_out <= sgpc_pkg::NV_HI);
  wire nv_last = nv_idx_reg == 3'(sgpc_pkg::NV_BLK_BYTES - 1);
  wire nv_rd_done = nv_idx_reg == 3'(sgpc_pkg::NV_BLK_BYTES + 1);
  assign nv_addr_out = nv_base + {13'h0000, nv_idx_reg};
  assign nv_wdata_out = wr_blk[{~nv_idx_reg[1:0], 3'h0} +: 8];
  assign nv_we_out = (nv_state_reg == sgpc_pkg::NV_WRITE) & program_key_in & nv_in_range;
  assign nv_re_out = (nv_state_reg == sgpc_pkg::NV_RESTORE) &
                     (nv_idx_reg < 3'(sgpc_pkg::NV_BLK_BYTES));
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      nv_state_reg <= sgpc_pkg::NV_RESTORE;
      nv_idx_reg <= 3'h0;
      nv_copy_reg <= 1'b0;
      rd_buf_reg <= 32'h0000_0000;
      set_reg <= 16'h0000;
      crc_reg <= sgpc_pkg::CRC_DFLT;
    end else begin
      unique case (nv_state_reg)
        sgpc_pkg::NV_RESTORE: begin
          if (nv_rd_done) begin
            if (rd_ok) begin
              set_reg <= rd_buf_reg[31:16];
              crc_reg <= rd_buf_reg[15:0];
              nv_state_reg <= sgpc_pkg::NV_IDLE;
            end else if (!nv_copy_reg) begin
              nv_copy_reg <= 1'b1;
              nv_idx_reg <= 3'h0;
            end else begin
              nv_state_reg <= sgpc_pkg::NV_IDLE;
            end
          end else begin
            nv_idx_reg <= nv_idx_reg + 3'h1;
            if (nv_idx_reg != 3'h0) rd_buf_reg <= {rd_buf_reg[23:0], nv_rdata_in};
          end
        end
        sgpc_pkg::NV_IDLE: begin
          if (settings_wr_in && program_key_in) begin
            set_reg <= settings_in;
            crc_reg <= sgpc_pkg::crc16(settings_in);
            nv_state_reg <= sgpc_pkg::NV_WRITE;
            nv_idx_reg <= 3'h0;
            nv_copy_reg <= 1'b0;
          end
        end
        sgpc_pkg::NV_WRITE: begin
          if (!nv_last) begin
            nv_idx_reg <= nv_idx_reg + 3'h1;
          end else begin
            nv_idx_reg <= 3'h0;
            nv_copy_reg <= ~nv_copy_reg;
            if (nv_copy_reg) nv_state_reg <= sgpc_pkg::NV_IDLE;
          end
        end
        default: nv_state_reg <= sgpc_pkg::NV_IDLE;
      endcase
    end
  end
  // Corruption can only come from upsets, so the request is sticky
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) wdog_reg <= 1'b0;
    else wdog_reg <= wdog_reg | ((nv_state_reg == sgpc_pkg::NV_IDLE) & crc_bad);
  end
  assign wdog_reset_out = wdog_reg;
  assign settings_out = set_reg;

  // Checks
  logic [15:0] ast_since_reg;
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) ast_since_reg <= 16'h0000;
    else if (g_strobe) ast_since_reg <= 16'h0001;
    else if (ast_since_reg != 16'hFFFF) ast_since_reg <= ast_since_reg + 16'h0001;
  end

  AST_OUT_TIME: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    out_load_out |-> ast_since_reg == 16'(AST_DLY))
    else $error("Output byte not presented at the set delay");
  AST_SER_LEN: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    st_ser |-> pk_len_reg <= 3'(sgpc_pkg::SER_MAX_DATA) && pk_len_reg != 3'h0)
    else $error("Serial packet length out of range");
  AST_TRL_END: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && trl_now |=> st_trl2 ##1 (!g_strobe && st_trl2)[*1] or st_idle)
    else $error("Trailer not followed by packet end");
  AST_CTL_FOUR: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_ctl && ctl_full |=> st_trl2 && pk_type_reg == sgpc_pkg::TYPE_CTL)
    else $error("Control packet not four data bytes");
  AST_CTL_CUT: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_ser && ctl_changed |=> st_trl2)
    else $error("Serial packet not cut on control change");
  AST_IDLE_FILL: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_idle && !main_avail && !aux_avail |=> st_ctl)
    else $error("Idle stream not filled with control packet");
  AST_ONE_EVENT: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    $onehot0({g_strobe, g_tick, g_rx}))
    else $error("More than one event serviced");
  AST_ERR_DROP: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_rx[0] && g_ch[0].head_err |=> q_cnt_w[0] == $past(q_cnt_w[0]))
    else $error("Bad character reached the queue");
  AST_AUX_PREF: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_idle && !ctl_due && aux_first |=> st_ser && pk_src_reg)
    else $error("Auxiliary queue not preferred");
  AST_NV_KEY: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    nv_we_out |-> program_key_in && nv_addr_out <= sgpc_pkg::NV_HI)
    else $error("NV write without program key");
  AST_TICK: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    g_tick && !timer_clear_in[1] |=> timer_w[1] == $past(timer_w[1]) + 16'h0001)
    else $error("Soft timer missed a tick");

  COV_CUT: cover property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_ser && ctl_changed);
  COV_AUX: cover property (@(posedge clk_sys_in) disable iff (!rstn)
    g_strobe && st_idle && !start_ctl && pick_aux);
  COV_OVF: cover property (@(posedge clk_sys_in) disable iff (!rstn)
    g_rx[0] && g_ch[0].q_ovf);
  COV_COPY_B: cover property (@(posedge clk_sys_in) disable iff (!rstn)
    nv_state_reg == sgpc_pkg::NV_RESTORE && nv_rd_done && nv_copy_reg && rd_ok);
endmodule

// ==== verif/sgpc_coder_model.sv ====
`timescale 1ns/100ps
module sgpc_coder_model #(
  parameter int PERIOD = 1100
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic enable_in,
  // Coder link
  output logic strobe_out,
  input wire logic load_in,
  output logic timing_bad_out
);
  // Period shortened from 3 ms to keep runs short; still above the retrigger spacing
  int cnt;
  logic owed;
  initial begin
    strobe_out = 1'b0;
    timing_bad_out = 1'b0;
    owed = 1'b0;
    cnt = 0;
  end
  always @(negedge clk_in) begin
    strobe_out <= 1'b0;
    cnt <= cnt + 1;
    if (load_in === 1'b1) begin
      if (!owed || cnt < sgpc_pkg::OUT_DELAY_CYC || cnt > sgpc_pkg::OUT_MAX_CYC) begin
        timing_bad_out <= 1'b1;
      end
      owed <= 1'b0;
    end
    if (enable_in && cnt >= PERIOD) begin
      if (owed) begin
        timing_bad_out <= 1'b1;
      end
      strobe_out <= 1'b1;
      owed <= 1'b1;
      cnt <= 0;
    end
  end
endmodule

// ==== verif/test_signalling_packet_combiner.sv ====
`timescale 1ns/100ps
module test_signalling_packet_combiner;
  typedef struct packed {logic ch; logic err; logic [7:0] data;} sgpc_row_s;
  localparam int TICK = 1000;
  logic clk_sys_in, rstn_in, strobe, load, key, wr, coder_en, late, nv_we, nv_re, wdog;
  logic [15:0] word, prev_word, tval, nv_addr;
  logic [7:0] obyte, nv_wdata, nv_rdata;
  logic [1:0] rdy, ovf, tsel;
  logic [3:0] tclr;
  sgpc_pkg::sgpc_rx_s [1:0] rx;
  sgpc_pkg::sgpc_settings_s set_in, set_out;
  logic [7:0] nv_mem [0:31];
  logic [7:0] expq [2][$];
  logic [7:0] pk [$];
  int bad_count, tests_run, ctl_seen;
  // Data bytes keep bits 5:3 nonzero so none can pass for a trailer
  sgpc_row_s rows [12] = '{'{1'b0, 1'b0, 8'h30}, '{1'b1, 1'b0, 8'h31}, '{1'b0, 1'b1, 8'h32},
    '{1'b0, 1'b0, 8'h33}, '{1'b0, 1'b0, 8'h34}, '{1'b1, 1'b1, 8'h35}, '{1'b0, 1'b0, 8'h36},
    '{1'b0, 1'b0, 8'h37}, '{1'b1, 1'b0, 8'h38}, '{1'b0, 1'b0, 8'h39}, '{1'b0, 1'b0, 8'h3A},
    '{1'b0, 1'b0, 8'h3B}};
  sgpc_combiner #(.TICK_CYCLES(TICK)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .strobe_in(strobe), .out_byte_out(obyte), .out_load_out(load),
    .transmitter_control_word_in(word), .rx_in(rx), .rx_ready_out(rdy), .q_overflow_out(ovf),
    .timer_clear_in(tclr), .timer_sel_in(tsel), .timer_value_out(tval),
    .program_key_in(key), .settings_wr_in(wr), .settings_in(set_in), .settings_out(set_out),
    .wdog_reset_out(wdog), .nv_addr_out(nv_addr), .nv_wdata_out(nv_wdata), .nv_we_out(nv_we),
    .nv_re_out(nv_re), .nv_rdata_in(nv_rdata));
  sgpc_coder_model #(.PERIOD(1100)) coder (.clk_in(clk_sys_in), .enable_in(coder_en),
    .strobe_out(strobe), .load_in(load), .timing_bad_out(late));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    check(late, 1'b0);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic ch, input logic err, input logic [7:0] d);
    rx[ch] = '{1'b1, err, d};
    @(negedge clk_sys_in);
    rx[ch] = '0;
    @(negedge clk_sys_in);
    if (!err) expq[ch].push_back(d);
  endtask
  task automatic parse(input logic [7:0] b);
    int n;
    logic [15:0] s;
    logic [1:0] t;
    pk.push_back(b);
    if (pk.size() > 9) begin
      check(pk.size(), 0);
      pk.delete();
    end
    if (pk.size() < 3) return;
    n = pk.size() - 2;
    t = pk[n][7:6];
    s = {8'h00, t, 3'h0, n[2:0]};
    for (int i = 0; i < n; i++) s += pk[i];
    if (t == 2'h3 || pk[n][2:0] != n[2:0] || pk[n][5:3] != s[13:11]) return;
    if (pk[n + 1] != s[7:0]) return;
    if (t == 2'h2) begin
      check(n, 4);
      check({pk[0], pk[1]}, 16'h0000);
      check({pk[2], pk[3]} == word || {pk[2], pk[3]} == prev_word, 1'b1);
      if ({pk[2], pk[3]} == word) ctl_seen++;
    end else begin
      for (int i = 0; i < n; i++) begin
        check(pk[i], expq[t].size() ? expq[t].pop_front() : 16'hFFFF);
      end
    end
    pk.delete();
  endtask
  always @(posedge clk_sys_in) begin
    if (nv_we) nv_mem[nv_addr[4:0]] <= nv_wdata;
    nv_rdata <= nv_re ? nv_mem[nv_addr[4:0]] : ~nv_rdata;
  end
  always @(negedge clk_sys_in) begin
    if (load === 1'b1) parse(obyte);
    if (nv_we === 1'b1) begin
      check(key && nv_addr >= sgpc_pkg::NV_LO && nv_addr <= sgpc_pkg::NV_HI, 1'b1);
    end
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    // Tests need about 60000 cycles; stay inside the run budget
    #9500000;
    bad_count++;
    complete_run();
  end
  initial begin
    rstn_in = 1'b0;
    {key, wr, coder_en, rx, set_in, tclr} = '0;
    word = 16'h3C3C;
    prev_word = word;
    tsel = 2'h1;
    for (int i = 0; i < 32; i++) nv_mem[i] = 8'h00;
    repeat (20) @(negedge clk_sys_in);
    check(rdy, 2'h3);
    check({ovf, wdog, load}, 16'h0000);
    rstn_in = 1'b1;
    repeat (30) @(negedge clk_sys_in);
    check(set_out, 16'h0000);
    foreach (rows[i]) send(rows[i].ch, rows[i].err, rows[i].data);
    coder_en = 1'b1;
    repeat (6) @(posedge load);
    @(negedge clk_sys_in);
    prev_word = word;
    word = 16'h3D3D;
    ctl_seen = 0;
    for (int k = 0; k < 30000 && ctl_seen == 0; k++) @(negedge clk_sys_in);
    check(ctl_seen != 0, 1'b1);
    for (int k = 0; k < 40000 && expq[0].size() + expq[1].size() > 0; k++) begin
      @(negedge clk_sys_in);
    end
    check(expq[0].size() + expq[1].size(), 0);
    coder_en = 1'b0;
    repeat (1200) @(negedge clk_sys_in);
    for (int i = 0; i < 18; i++) send(1'b1, 1'b0, 8'h30 + i[7:0]);
    void'(expq[1].pop_back());
    void'(expq[1].pop_back());
    check(ovf, 2'h2);
    check(rdy, 2'h1);
    coder_en = 1'b1;
    tclr = 4'h2;
    @(negedge clk_sys_in);
    tclr = 4'h0;
    repeat (3 * TICK) @(negedge clk_sys_in);
    check(tval == 16'h0003 || tval == 16'h0002, 1'b1);
    for (int k = 0; k < 45000 && expq[1].size() > 0; k++) @(negedge clk_sys_in);
    check(expq[1].size(), 0);
    check(rdy, 2'h3);
    coder_en = 1'b0;
    repeat (1200) @(negedge clk_sys_in);
    set_in = 16'h3A3B;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    check(set_out, 16'h0000);
    key = 1'b1;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    key = 1'b0;
    check(set_out, 16'h3A3B);
    check({nv_mem[0], nv_mem[1]}, 16'h3A3B);
    check({nv_mem[16], nv_mem[17]}, 16'h3A3B);
    // Spoil copy A so restore has to fall back on copy B
    nv_mem[0] = 8'h00;
    rstn_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (40) @(negedge clk_sys_in);
    check(set_out, 16'h3A3B);
    check(wdog, 1'b0);
    complete_run();
  end
endmodule
